// file: rtl/fttt_fan_tach_thermal_trip.sv
// Thermal trip output and four fan tach period meters with registers.
// Assumes temperatures and drive levels arrive on core_clk; tach pins
// are asynchronous.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps

module fttt_fan_tach_thermal_trip
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrStrobe,
  input  wire logic       regRdStrobe,
  output logic      [7:0] regRdData,
  input  wire logic [9:0] tempRemoteOne,
  input  wire logic [9:0] tempLocal,
  input  wire logic [9:0] tempRemoteTwo,
  input  wire logic [2:0] tempValid,
  input  wire logic       fanDriveOne,
  input  wire logic       fanDriveTwo,
  input  wire logic       fanDriveThree,
  input  wire logic       highFreqMode,
  input  wire logic       tachInOne,
  input  wire logic       tachInTwo,
  input  wire logic       tachInThree,
  input  wire logic       tachInFour,
  output logic            thermalAlarmOut,
  output logic            thermalAlarmOe
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]  groupSync_ff;
  logic [7:0]  limit_ff [fttt_pkg::NUM_TEMP];
  logic [7:0]  configThree_ff;
  logic [7:0]  pulsesRev_ff;
  logic [7:0]  configFive_ff;
  logic [7:0]  pinFunc_ff;
  logic [7:0]  regRdData_ff;
  logic [7:0]  nxt_regRdData;
  logic [2:0]  trip_ff;
  logic [2:0]  above;
  logic [2:0]  limitOff;
  logic [9:0]  tempCh [fttt_pkg::NUM_TEMP];
  logic        thermalAlarmOe_ff;
  logic        thermalAlarmOut_ff;
  logic [7:0]  refDiv_ff;
  logic        refTick_ff;
  logic [3:0]  tachPin;
  logic [3:0]  tachMeta_ff;
  logic [3:0]  tachSync_ff;
  logic [3:0]  tachLast_ff;
  logic [3:0]  driveSel;
  logic [3:0]  tachLock_ff;
  logic [15:0] tachResult_ff [fttt_pkg::NUM_TACH];
  logic        tachHit;
  logic [3:0]  lowRead;
  logic [3:0]  highRead;
  logic        twosFmt;

  assign regRdData       = regRdData_ff;
  assign thermalAlarmOe  = thermalAlarmOe_ff;
  assign thermalAlarmOut = thermalAlarmOut_ff;
  assign tempCh[0]       = tempRemoteOne;
  assign tempCh[1]       = tempLocal;
  assign tempCh[2]       = tempRemoteTwo;
  assign tachPin         = {tachInFour, tachInThree, tachInTwo, tachInOne};
  assign twosFmt         = configFive_ff[fttt_pkg::TWOS_FMT_BIT];
  assign tachHit         = (regAddr[7:3] == fttt_pkg::ADDR_TACH_BASE[7:3]);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      groupSync_ff   <= fttt_pkg::RST_GROUP_SYNC;
      limit_ff[0]    <= fttt_pkg::RST_LIMIT;
      limit_ff[1]    <= fttt_pkg::RST_LIMIT;
      limit_ff[2]    <= fttt_pkg::RST_LIMIT;
      configThree_ff <= fttt_pkg::RST_CONFIG_3;
      pulsesRev_ff   <= fttt_pkg::RST_PULSES_REV;
      configFive_ff  <= fttt_pkg::RST_CONFIG_5;
      pinFunc_ff     <= fttt_pkg::RST_PIN_FUNC;
    end
    else if (regWrStrobe)
    begin
      unique case (regAddr)
        fttt_pkg::ADDR_GROUP_SYNC:  groupSync_ff   <= regWrData;
        fttt_pkg::ADDR_LIMIT_R1:    limit_ff[0]    <= regWrData;
        fttt_pkg::ADDR_LIMIT_LOCAL: limit_ff[1]    <= regWrData;
        fttt_pkg::ADDR_LIMIT_R2:    limit_ff[2]    <= regWrData;
        fttt_pkg::ADDR_CONFIG_3:    configThree_ff <= regWrData;
        fttt_pkg::ADDR_PULSES_REV:  pulsesRev_ff   <= regWrData;
        fttt_pkg::ADDR_CONFIG_5:    configFive_ff  <= regWrData;
        fttt_pkg::ADDR_PIN_FUNC:    pinFunc_ff     <= regWrData;
        default:                    ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_regRdData = 8'h00;
    if (tachHit)
      nxt_regRdData = regAddr[0] ? tachResult_ff[regAddr[2:1]][15:8]
                                 : tachResult_ff[regAddr[2:1]][7:0];
    else
    begin
      unique case (regAddr)
        fttt_pkg::ADDR_GROUP_SYNC:  nxt_regRdData = groupSync_ff;
        fttt_pkg::ADDR_LIMIT_R1:    nxt_regRdData = limit_ff[0];
        fttt_pkg::ADDR_LIMIT_LOCAL: nxt_regRdData = limit_ff[1];
        fttt_pkg::ADDR_LIMIT_R2:    nxt_regRdData = limit_ff[2];
        fttt_pkg::ADDR_CONFIG_3:    nxt_regRdData = configThree_ff;
        fttt_pkg::ADDR_PULSES_REV:  nxt_regRdData = pulsesRev_ff;
        fttt_pkg::ADDR_CONFIG_5:    nxt_regRdData = configFive_ff;
        fttt_pkg::ADDR_PIN_FUNC:    nxt_regRdData = pinFunc_ff;
        default:                    nxt_regRdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      regRdData_ff <= 8'h00;
    else
      regRdData_ff <= regRdStrobe ? nxt_regRdData : 8'h00;
  end

  // ----------------------------------------------------------------
  // Thermal trip compare
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < fttt_pkg::NUM_TEMP; i++)
    begin
      limitOff[i] = twosFmt ? (limit_ff[i] == fttt_pkg::TWOS_OFF_CODE)
                            : (limit_ff[i] == fttt_pkg::OFF64_OFF_CODE);
      if (twosFmt)
        above[i] = $signed(tempCh[i]) >
                   $signed({limit_ff[i], {fttt_pkg::TEMP_FRAC_BITS{1'b0}}});
      else
        above[i] = tempCh[i] > {limit_ff[i], {fttt_pkg::TEMP_FRAC_BITS{1'b0}}};
    end
  end

  // Channel state changes only on its own conversion
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      trip_ff <= 3'h0;
    else
    begin
      for (int i = 0; i < fttt_pkg::NUM_TEMP; i++)
        if (tempValid[i])
          trip_ff[i] <= above[i] && !limitOff[i];
    end
  end

  // Open-drain pin: drive low or release
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      thermalAlarmOe_ff  <= 1'b0;
      thermalAlarmOut_ff <= 1'b0;
    end
    else
    begin
      thermalAlarmOut_ff <= 1'b0;
      thermalAlarmOe_ff  <= configThree_ff[fttt_pkg::ALARM_EN_BIT]
        && |(trip_ff & configFive_ff[fttt_pkg::CH_EN_LSB +: 3]);
    end
  end

  // ----------------------------------------------------------------
  // 90 kHz reference tick
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      refDiv_ff  <= 8'h00;
      refTick_ff <= 1'b0;
    end
    else
    begin
      refTick_ff <= (refDiv_ff == fttt_pkg::REF_DIV_LAST);
      refDiv_ff  <= (refDiv_ff == fttt_pkg::REF_DIV_LAST) ? 8'h00
                                                          : refDiv_ff + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Tach pin synchronisers and edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      tachMeta_ff <= 4'hF;
      tachSync_ff <= 4'hF;
      tachLast_ff <= 4'hF;
    end
    else
    begin
      tachMeta_ff <= tachPin;
      tachSync_ff <= tachMeta_ff;
      tachLast_ff <= tachSync_ff;
    end
  end

  // Drive channel each meter follows
  always_comb
  begin
    driveSel[0] = fanDriveOne;
    driveSel[1] = groupSync_ff[fttt_pkg::SYNC_BIT] ? fanDriveThree
                                                   : fanDriveTwo;
    driveSel[2] = fanDriveThree;
    driveSel[3] = fanDriveThree;
  end

  // ----------------------------------------------------------------
  // Meters and result registers
  // ----------------------------------------------------------------
  fttt_tach_if tachBus [fttt_pkg::NUM_TACH] ();

  genvar g;
  generate
    for (g = 0; g < fttt_pkg::NUM_TACH; g++)
    begin : gen_tach
      assign tachBus[g].refTick  = refTick_ff;
      assign tachBus[g].tachRise = tachSync_ff[g] && !tachLast_ff[g];
      assign tachBus[g].syncOk   = highFreqMode || driveSel[g];
      assign tachBus[g].pulseSel = pulsesRev_ff[2*g +: 2];
      if (g == 3)
      begin : gen_shared
        assign tachBus[g].enable = (pinFunc_ff[1:0] == fttt_pkg::PIN_FUNC_TACH);
      end
      else
      begin : gen_plain
        assign tachBus[g].enable = 1'b1;
      end

      assign lowRead[g]  = regRdStrobe && tachHit && (regAddr[2:1] == 2'(g))
                           && !regAddr[0];
      assign highRead[g] = regRdStrobe && tachHit && (regAddr[2:1] == 2'(g))
                           && regAddr[0];

      fttt_tach_meter u_meter
      (
        .core_clk (core_clk),
        .reset    (reset),
        .tach     (tachBus[g])
      );

      // Locked from reset until the high byte is read
      always_ff @(posedge core_clk or posedge reset)
      begin
        if (reset)
          tachLock_ff[g] <= 1'b1;
        else if (lowRead[g])
          tachLock_ff[g] <= 1'b1;
        else if (highRead[g])
          tachLock_ff[g] <= 1'b0;
      end

      always_ff @(posedge core_clk or posedge reset)
      begin
        if (reset)
          tachResult_ff[g] <= 16'h0000;
        else if (tachBus[g].resultValid && !tachLock_ff[g] && !lowRead[g])
          tachResult_ff[g] <= tachBus[g].result;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence seqTripped;
    trip_ff[0] ##1 (tempValid[0] && above[0] && !limitOff[0]);
  endsequence

  sequence seqLowRead;
    regRdStrobe && tachHit && (regAddr[2:1] == 2'h0) && !regAddr[0];
  endsequence

  chk_trip_on_exceed: assert property (
    tempValid[0] && above[0] && !limitOff[0] |=> trip_ff[0])
    else $error("channel did not trip above limit");

  chk_trip_stays_low: assert property (
    seqTripped |=> trip_ff[0])
    else $error("trip released while still above limit");

  chk_trip_release: assert property (
    tempValid[1] && !above[1] |=> !trip_ff[1])
    else $error("trip not released at or below limit");

  chk_trip_held_cycle: assert property (
    trip_ff[2] && !tempValid[2] |=> trip_ff[2])
    else $error("trip dropped between conversions");

  chk_disabled_limit: assert property (
    tempValid[0] && limitOff[0] |=> !trip_ff[0])
    else $error("minimum limit code tripped the alarm");

  chk_pin_follows_trip: assert property (
    configThree_ff[fttt_pkg::ALARM_EN_BIT] && trip_ff[1]
      && configFive_ff[fttt_pkg::CH_EN_LSB + 1] |=> thermalAlarmOe_ff)
    else $error("enabled trip did not pull the pin");

  chk_pin_disabled: assert property (
    !configThree_ff[fttt_pkg::ALARM_EN_BIT] |=> !thermalAlarmOe_ff)
    else $error("pin driven while function disabled");

  chk_pin_only_low: assert property (
    !thermalAlarmOut_ff)
    else $error("alarm pin driven high");

  chk_high_byte_frozen: assert property (
    seqLowRead ##1 !highRead[0] |=> $stable(tachResult_ff[0]))
    else $error("tach result changed between byte reads");

  chk_ref_tick_rate: assert property (
    $rose(refTick_ff) |=> !refTick_ff [*8])
    else $error("reference tick too frequent");

endmodule // fttt_fan_tach_thermal_trip

// file: rtl/fttt_pkg.sv
// Constants, register map and types for the fan tach and thermal trip block.
// Assumes one 20 MHz core clock and a byte-wide register port.
// Functional notes
// - Alarm low when temp exceeds limit by 0.25C
// - Alarm stays low while still above limit
// - Alarm releases when temp at or below limit
// - Alarm low at least one monitoring cycle
// - Three critical limits at consecutive addresses
// - Config five bits 5..7 enable channel alarms
// - Minimum-code limit never trips the alarm
// - Config three bit 1 clear disables alarm
// - Drive uses low or high frequency mode
// - Tach one to drive one, three/four to three
// - Group sync puts tach two..four on three
// - High frequency mode bypasses drive sync
// - Tach four only when pin set for tach
// - Count 90 kHz reference over N periods
// - Larger count means slower fan
// - Pulses per rev field, default two pulses
// - Codes 00..11 select one..four pulses
// - All ones reading means stalled fan
// - Low byte read freezes high byte

package fttt_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TACH_BASE   = 8'h28;
  localparam logic [7:0] ADDR_GROUP_SYNC  = 8'h62;
  localparam logic [7:0] ADDR_LIMIT_R1    = 8'h6A;
  localparam logic [7:0] ADDR_LIMIT_LOCAL = 8'h6B;
  localparam logic [7:0] ADDR_LIMIT_R2    = 8'h6C;
  localparam logic [7:0] ADDR_CONFIG_3    = 8'h78;
  localparam logic [7:0] ADDR_PULSES_REV  = 8'h7B;
  localparam logic [7:0] ADDR_CONFIG_5    = 8'h7C;
  localparam logic [7:0] ADDR_PIN_FUNC    = 8'h7D;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_GROUP_SYNC = 8'h00;
  localparam logic [7:0] RST_LIMIT      = 8'h64;
  localparam logic [7:0] RST_CONFIG_3   = 8'h00;
  localparam logic [7:0] RST_PULSES_REV = 8'h55;
  localparam logic [7:0] RST_CONFIG_5   = 8'h00;
  localparam logic [7:0] RST_PIN_FUNC   = 8'h00;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int         SYNC_BIT        = 4;
  localparam int         ALARM_EN_BIT    = 1;
  localparam int         TWOS_FMT_BIT    = 0;
  localparam int         CH_EN_LSB       = 5;
  localparam logic [1:0] PIN_FUNC_TACH   = 2'h1;
  localparam logic [7:0] OFF64_OFF_CODE  = 8'h00;
  localparam logic [7:0] TWOS_OFF_CODE   = 8'h80;
  localparam int         TEMP_FRAC_BITS  = 2;
  localparam int         NUM_TEMP        = 3;
  localparam int         NUM_TACH        = 4;
  localparam logic [15:0] TACH_MAX       = 16'hFFFF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         CLK_HZ         = 20_000_000;
  localparam int         REF_HZ         = 90_000;
  localparam int         REF_DIV_CYCLES = CLK_HZ / REF_HZ;
  localparam logic [7:0] REF_DIV_LAST   = 8'(REF_DIV_CYCLES - 1);

  typedef enum logic [0:0] {
    TM_IDLE  = 1'b0,
    TM_COUNT = 1'b1
  } fttt_meter_state_t;

endpackage

// file: rtl/fttt_tach_if.sv
// Link between the top block and one tach period meter.
// Assumes all signals run on core_clk.
`timescale 1ns/1ps

interface fttt_tach_if;
  logic        refTick;
  logic        tachRise;
  logic        syncOk;
  logic        enable;
  logic [1:0]  pulseSel;
  logic [15:0] result;
  logic        resultValid;

  modport ctrl  (output refTick, tachRise, syncOk, enable, pulseSel,
                 input  result, resultValid);
  modport meter (input  refTick, tachRise, syncOk, enable, pulseSel,
                 output result, resultValid);
endinterface

// file: rtl/fttt_tach_meter.sv
// Period meter for one tach input.
// Assumes tachRise is a one-cycle pulse already synchronised.
`timescale 1ns/1ps

module fttt_tach_meter
(
  input  wire logic core_clk,
  input  wire logic reset,
  fttt_tach_if.meter  tach
);

  fttt_pkg::fttt_meter_state_t state_ff;
  logic [15:0]                 count_ff;
  logic [1:0]                  edges_ff;
  logic [15:0]                 result_ff;
  logic                        valid_ff;

  assign tach.result      = result_ff;
  assign tach.resultValid = valid_ff;

  // ----------------------------------------------------------------
  // Gate reference clock across N tach periods
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state_ff  <= fttt_pkg::TM_IDLE;
      count_ff  <= 16'h0000;
      edges_ff  <= 2'h0;
      result_ff <= 16'h0000;
      valid_ff  <= 1'b0;
    end
    else
    begin
      valid_ff <= 1'b0;
      unique case (state_ff)
        fttt_pkg::TM_IDLE:
        begin
          if (tach.enable && tach.syncOk && tach.tachRise)
          begin
            state_ff <= fttt_pkg::TM_COUNT;
            count_ff <= 16'h0000;
            edges_ff <= 2'h0;
          end
        end
        fttt_pkg::TM_COUNT:
        begin
          if (!tach.enable || !tach.syncOk)
            state_ff <= fttt_pkg::TM_IDLE;
          else if (count_ff == fttt_pkg::TACH_MAX)
          begin
            result_ff <= fttt_pkg::TACH_MAX;
            valid_ff  <= 1'b1;
            state_ff  <= fttt_pkg::TM_IDLE;
          end
          else if (tach.tachRise && (edges_ff >= tach.pulseSel))
          begin
            result_ff <= count_ff + {15'h0000, tach.refTick};
            valid_ff  <= 1'b1;
            count_ff  <= 16'h0000;
            edges_ff  <= 2'h0;
          end
          else
          begin
            if (tach.tachRise)
              edges_ff <= edges_ff + 2'h1;
            if (tach.refTick)
              count_ff <= count_ff + 16'h0001;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  chk_stall_reports_max: assert property (
    (state_ff == fttt_pkg::TM_COUNT) && (count_ff == fttt_pkg::TACH_MAX)
      && tach.enable && tach.syncOk
    |=> valid_ff && (result_ff == fttt_pkg::TACH_MAX))
    else $error("stalled count not reported as all ones");

  chk_count_no_wrap: assert property (
    (state_ff == fttt_pkg::TM_COUNT) && (count_ff != 16'h0000)
      && !valid_ff && $past(state_ff == fttt_pkg::TM_COUNT)
    |-> count_ff >= $past(count_ff))
    else $error("tach counter wrapped");

endmodule // fttt_tach_meter

// file: bench/fttt_fan_model.sv
// Fan model: open-drain tach output with a fixed period.
// Assumes core_clk timing; line pulled up while the fan stands.
`timescale 1ns/1ps

module fttt_fan_model
#(
  parameter int PERIOD_CLKS = 2220
)
(
  input  wire logic core_clk,
  input  wire logic spinning,
  output logic      tachOut
);
  // ----------------------------------------------------------------
  // Tach pulse train, one rising edge per period
  // ----------------------------------------------------------------
  int phaseCnt = 0;

  always @(posedge core_clk)
  begin
    phaseCnt <= (phaseCnt == PERIOD_CLKS - 1) ? 0 : phaseCnt + 1;
    tachOut  <= spinning ? (phaseCnt < PERIOD_CLKS / 2) : 1'b1;
  end
endmodule // fttt_fan_model

// file: bench/tb_top.sv
// Self-checking bench for the fan tach and thermal trip block.
// Assumes fttt_pkg compiled first and a 50 ns core clock.
`timescale 1ns/1ps

module tb_top;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic        core_clk = 1'b0;
  logic        reset    = 1'b1;
  logic [7:0]  regAddr  = 8'h00;
  logic [7:0]  regWrData = 8'h00;
  logic        regWrStrobe = 1'b0;
  logic        regRdStrobe = 1'b0;
  logic [7:0]  regRdData;
  logic [9:0]  tempCode [3] = '{10'h000, 10'h000, 10'h000};
  logic [2:0]  tempValid = 3'h0;
  logic [2:0]  fanDrive  = 3'h5;
  logic        highFreqMode = 1'b0;
  logic        fanTach;
  logic        thermalAlarmOut;
  logic        thermalAlarmOe;
  int          err_count = 0;
  int          checks    = 0;
  logic [7:0]  rdVal;

  always #25 core_clk = ~core_clk;

  fttt_fan_model i_fttt_fan_model (.core_clk(core_clk), .spinning(1'b1), .tachOut(fanTach));

  fttt_fan_tach_thermal_trip i_fttt_fan_tach_thermal_trip (
    .core_clk(core_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
    .tempRemoteOne(tempCode[0]), .tempLocal(tempCode[1]), .tempRemoteTwo(tempCode[2]),
    .tempValid(tempValid), .fanDriveOne(fanDrive[0]), .fanDriveTwo(fanDrive[1]),
    .fanDriveThree(fanDrive[2]), .highFreqMode(highFreqMode), .tachInOne(fanTach),
    .tachInTwo(fanTach), .tachInThree(fanTach), .tachInFour(fanTach),
    .thermalAlarmOut(thermalAlarmOut), .thermalAlarmOe(thermalAlarmOe));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr     <= a;
    regWrData   <= d;
    regWrStrobe <= 1'b1;
    @(posedge core_clk);
    regWrStrobe <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr     <= a;
    regRdStrobe <= 1'b1;
    @(posedge core_clk);
    regRdStrobe <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic rd_tach(input int ch, input logic [15:0] exp);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(8'(8'h28 + 2 * ch), lo);
    rd(8'(8'h29 + 2 * ch), hi);
    check("tach result", {hi, lo}, exp);
  endtask

  task automatic temp_alarm(input int ch, input logic [9:0] t, input logic exp);
    @(posedge core_clk);
    tempCode[ch]  <= t;
    tempValid[ch] <= 1'b1;
    @(posedge core_clk);
    tempValid[ch] <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 check("alarm drive", thermalAlarmOe, exp);
    check("alarm level", thermalAlarmOut, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_values();
    logic [7:0] addrs [8] = '{8'h62, 8'h6A, 8'h6B, 8'h6C, 8'h78, 8'h7B, 8'h7C, 8'h10};
    logic [7:0] exps  [8] = '{fttt_pkg::RST_GROUP_SYNC, fttt_pkg::RST_LIMIT,
      fttt_pkg::RST_LIMIT, fttt_pkg::RST_LIMIT, fttt_pkg::RST_CONFIG_3,
      fttt_pkg::RST_PULSES_REV, fttt_pkg::RST_CONFIG_5, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      rd(addrs[i], rdVal);
      check("reset value", rdVal, exps[i]);
    end
    @(posedge core_clk);
    #1 check("read data idle", regRdData, 8'h00);
    wr(8'h10, 8'h5A);
    rd(8'h10, rdVal);
    check("unmapped read", rdVal, 8'h00);
  endtask

  task automatic test_alarm();
    wr(8'h78, 8'h02);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'(8'h6A + i), 8'h50);
      wr(8'h7C, 8'h00);
      temp_alarm(i, 10'h141, 1'b0);
      wr(8'h7C, 8'(8'h20 << i));
      temp_alarm(i, 10'h140, 1'b0);
      temp_alarm(i, 10'h141, 1'b1);
      temp_alarm(i, 10'h180, 1'b1);
      temp_alarm(i, 10'h140, 1'b0);
    end
    wr(8'h7C, 8'h20);
    wr(8'h6A, fttt_pkg::OFF64_OFF_CODE);
    temp_alarm(0, 10'h3FF, 1'b0);
    wr(8'h7C, 8'h21);
    wr(8'h6A, fttt_pkg::TWOS_OFF_CODE);
    temp_alarm(0, 10'h3FF, 1'b0);
    wr(8'h6A, 8'h50);
    temp_alarm(0, 10'h3FF, 1'b0);
    temp_alarm(0, 10'h141, 1'b1);
    repeat (5) @(posedge core_clk);
    #1 check("alarm held", thermalAlarmOe, 1'b1);
    wr(8'h78, 8'h00);
    @(posedge core_clk);
    #1 check("alarm disabled", thermalAlarmOe, 1'b0);
  endtask

  task automatic test_tach();
    rd(8'h29, rdVal);
    rd(8'h2B, rdVal);
    rd(8'h2F, rdVal);
    repeat (5 * 2220) @(posedge core_clk);
    rd_tach(0, 16'd20);
    rd_tach(1, 16'd0);
    rd_tach(3, 16'd0);
    wr(8'h62, 8'h10);
    repeat (5 * 2220) @(posedge core_clk);
    rd_tach(1, 16'd20);
    wr(8'h7B, 8'h54);
    wr(8'h7D, 8'h01);
    highFreqMode <= 1'b1;
    fanDrive     <= 3'h0;
    repeat (5 * 2220) @(posedge core_clk);
    rd_tach(0, 16'd10);
    rd_tach(1, 16'd20);
    rd_tach(3, 16'd20);
  endtask

  // ----------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge core_clk);
    err_count++;
    give_verdict();
  end

  initial
  begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    test_reset_values();
    test_alarm();
    test_tach();
    give_verdict();
  end
endmodule // tb_top
